// ===== logic/rpf_framer.sv
// physical-layer packet framer: transmit framing and receive deframing
// assumes octet-level air ports; modulation and fcs arithmetic are outside
// Behaviour
// - transmit four zero preamble octets then delimiter 0xa7
// - header generated here; host buffer holds only length and payload
// - header lasts 160 us, ten symbols, before the length octet
// - transmission may start early; buffer bytes taken as they arrive
// - receive syncs on preamble; matching delimiter starts length octet
// - low seven bits of length octet give payload length
// - top length bit carried unchanged both ways, excluded from length
// - received length octet is first byte of a buffer read
// - nonzero received length raises receive-start interrupt
// - zero-length received frames dropped silently, no interrupt, no content
// - final two payload octets are the frame check sequence
// - length 5 acknowledge, 9 and up mac frame, others reserved
// - header at 250 kb/s, payload at selected rate
// - maximum payload 4.064 ms at 250 down to 0.508 ms at 2000
// - first two payload octets form 16-bit frame control field
`timescale 1ns/10ps
`default_nettype none
module rpf_framer (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       tx_start,
  input  wire logic [1:0] tx_rate,
  input  wire logic       tx_wr_valid,
  input  wire logic [7:0] tx_wr_data,
  output logic            tx_busy,
  output logic [7:0]      tx_octet,
  output logic            tx_octet_valid,
  output logic            tx_done,
  output logic            tx_underrun,
  input  wire logic       rx_active,
  input  wire logic       rx_octet_valid,
  input  wire logic [7:0] rx_octet,
  output logic            rx_start_irq,
  output logic            rx_done,
  output logic            rx_frame_avail,
  output logic [1:0]      rx_kind,
  output logic [15:0]     rx_fcf,
  output logic [15:0]     rx_fcs,
  input  wire logic       rx_rd_req,
  output logic [7:0]      rx_rd_data,
  output logic            rx_rd_valid
);

  // ----------------------------------------------------------------
  // transmit state
  // ----------------------------------------------------------------
  rpf_pkg::rpf_tx_state_e    tx_state_q;
  logic [2:0]                tx_idx_q;
  logic [7:0]                tx_rd_q;
  logic [7:0]                tx_wr_q;
  logic [7:0]                tx_wr_base;
  logic [6:0]                tx_len_q;
  logic [6:0]                tx_cnt_q;
  logic [1:0]                tx_rate_q;
  logic [7:0]                tx_octet_q;
  logic                      tx_octet_valid_q;
  logic                      tx_done_q;
  logic                      tx_underrun_q;
  logic [7:0]                tx_buf [rpf_pkg::BUF_DEPTH];
  logic [rpf_pkg::TIM_W-1:0] rate_period;
  logic [rpf_pkg::TIM_W-1:0] tim_period;
  logic                      tim_tick;
  logic                      tx_go;
  logic                      tx_avail;
  logic                      tx_end;

  assign tx_go          = (tx_state_q == rpf_pkg::TX_IDLE) && tx_start;
  assign tx_avail       = tx_rd_q < tx_wr_q;
  assign tx_end         = tx_done_q || tx_underrun_q;
  assign tx_busy        = tx_state_q != rpf_pkg::TX_IDLE;
  assign tx_octet       = tx_octet_q;
  assign tx_octet_valid = tx_octet_valid_q;
  assign tx_done        = tx_done_q;
  assign tx_underrun    = tx_underrun_q;

  always_comb begin
    case (tx_rate_q)
      rpf_pkg::RATE_500: rate_period = rpf_pkg::P500;
      rpf_pkg::RATE_1K:  rate_period = rpf_pkg::P1K;
      rpf_pkg::RATE_2K:  rate_period = rpf_pkg::P2K;
      default:           rate_period = rpf_pkg::P250;
    endcase
  end

  // header slots at 250 kb/s, payload slots at the chosen rate
  assign tim_period = (tx_state_q == rpf_pkg::TX_PHR || tx_state_q == rpf_pkg::TX_PSDU) ?
                      rate_period : rpf_pkg::HDR_PERIOD;

  rpf_octet_timer u_timer (
    .clk    (clk),
    .rst_b  (rst_b),
    .start  (tx_go),
    .stop   (tx_end),
    .period (tim_period),
    .tick   (tim_tick)
  );

  // ----------------------------------------------------------------
  // host fill of the transmit buffer
  // ----------------------------------------------------------------
  assign tx_wr_base = tx_end ? 8'h00 : tx_wr_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_wr_q <= 8'h00;
    end else if (tx_wr_valid && tx_wr_base < rpf_pkg::BUF_FULL) begin
      tx_wr_q <= tx_wr_base + 8'h01;
    end else begin
      tx_wr_q <= tx_wr_base;
    end
  end

  always_ff @(posedge clk) begin
    if (tx_wr_valid && tx_wr_base < rpf_pkg::BUF_FULL) begin
      tx_buf[tx_wr_base[6:0]] <= tx_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // transmit sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_q       <= rpf_pkg::TX_IDLE;
      tx_idx_q         <= 3'h0;
      tx_rd_q          <= 8'h00;
      tx_len_q         <= 7'h00;
      tx_cnt_q         <= 7'h00;
      tx_rate_q        <= 2'h0;
      tx_octet_q       <= 8'h00;
      tx_octet_valid_q <= 1'b0;
      tx_done_q        <= 1'b0;
      tx_underrun_q    <= 1'b0;
    end else begin
      tx_octet_valid_q <= 1'b0;
      tx_done_q        <= 1'b0;
      tx_underrun_q    <= 1'b0;
      case (tx_state_q)
        rpf_pkg::TX_IDLE: begin
          if (tx_start) begin
            tx_state_q       <= rpf_pkg::TX_SHR;
            tx_rate_q        <= tx_rate;
            tx_idx_q         <= 3'h1;
            tx_rd_q          <= 8'h00;
            tx_octet_q       <= rpf_pkg::PRE_BYTE;
            tx_octet_valid_q <= 1'b1;
          end
        end
        rpf_pkg::TX_SHR: begin
          if (tim_tick && tx_idx_q < rpf_pkg::SHR_OCTETS) begin
            tx_octet_q       <= (tx_idx_q == rpf_pkg::PRE_OCTETS) ?
                                rpf_pkg::SFD_BYTE : rpf_pkg::PRE_BYTE;
            tx_octet_valid_q <= 1'b1;
            tx_idx_q         <= tx_idx_q + 3'h1;
          end else if (tim_tick && tx_avail) begin
            tx_octet_q       <= tx_buf[tx_rd_q[6:0]];
            tx_len_q         <= tx_buf[tx_rd_q[6:0]][6:0];
            tx_octet_valid_q <= 1'b1;
            tx_rd_q          <= tx_rd_q + 8'h01;
            tx_state_q       <= rpf_pkg::TX_PHR;
          end else if (tim_tick) begin
            tx_underrun_q    <= 1'b1;
            tx_state_q       <= rpf_pkg::TX_IDLE;
          end
        end
        rpf_pkg::TX_PHR, rpf_pkg::TX_PSDU: begin
          if (tim_tick && (tx_state_q == rpf_pkg::TX_PSDU ? tx_cnt_q == tx_len_q :
                           tx_len_q == 7'h00)) begin
            tx_done_q        <= 1'b1;
            tx_state_q       <= rpf_pkg::TX_IDLE;
          end else if (tim_tick && tx_avail) begin
            tx_octet_q       <= tx_buf[tx_rd_q[6:0]];
            tx_octet_valid_q <= 1'b1;
            tx_rd_q          <= tx_rd_q + 8'h01;
            tx_cnt_q         <= (tx_state_q == rpf_pkg::TX_PHR) ? 7'h01 : tx_cnt_q + 7'h01;
            tx_state_q       <= rpf_pkg::TX_PSDU;
          end else if (tim_tick) begin
            tx_underrun_q    <= 1'b1;
            tx_state_q       <= rpf_pkg::TX_IDLE;
          end
        end
        default: tx_state_q <= rpf_pkg::TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive deframer
  // ----------------------------------------------------------------
  rpf_pkg::rpf_rx_state_e rx_state_q;
  logic [2:0]             rx_zero_q;
  logic [6:0]             rx_len_q;
  logic [6:0]             rx_cnt_q;
  logic [7:0]             rx_prev_q;
  logic [7:0]             rx_buf [rpf_pkg::BUF_DEPTH];
  logic                   rx_start_q;
  logic                   rx_done_q;
  logic                   rx_frame_q;
  logic [1:0]             rx_kind_q;
  logic [15:0]            rx_fcf_q;
  logic [15:0]            rx_fcs_q;
  logic [6:0]             rx_ptr_q;
  logic [7:0]             rx_rd_data_q;
  logic                   rx_rd_valid_q;
  logic                   rx_accept;
  logic                   rx_store;

  assign rx_accept      = (rx_state_q == rpf_pkg::RX_LEN) && rx_active && rx_octet_valid &&
                          (rx_octet[6:0] != 7'h00);
  assign rx_store       = (rx_state_q == rpf_pkg::RX_BODY) && rx_active && rx_octet_valid;
  assign rx_start_irq   = rx_start_q;
  assign rx_done        = rx_done_q;
  assign rx_frame_avail = rx_frame_q;
  assign rx_kind        = rx_kind_q;
  assign rx_fcf         = rx_fcf_q;
  assign rx_fcs         = rx_fcs_q;
  assign rx_rd_data     = rx_rd_data_q;
  assign rx_rd_valid    = rx_rd_valid_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state_q <= rpf_pkg::RX_HUNT;
      rx_zero_q  <= 3'h0;
      rx_len_q   <= 7'h00;
      rx_cnt_q   <= 7'h00;
      rx_prev_q  <= 8'h00;
      rx_start_q <= 1'b0;
      rx_done_q  <= 1'b0;
      rx_frame_q <= 1'b0;
      rx_kind_q  <= rpf_pkg::KIND_RSVD;
      rx_fcf_q   <= 16'h0000;
      rx_fcs_q   <= 16'h0000;
    end else begin
      rx_start_q <= 1'b0;
      rx_done_q  <= 1'b0;
      if (!rx_active) begin
        rx_state_q <= rpf_pkg::RX_HUNT;
        rx_zero_q  <= 3'h0;
      end else if (rx_octet_valid) begin
        case (rx_state_q)
          rpf_pkg::RX_HUNT: begin
            if (rx_octet != rpf_pkg::PRE_BYTE) begin
              rx_zero_q  <= 3'h0;
            end else if (rx_zero_q + 3'h1 == rpf_pkg::PRE_OCTETS) begin
              rx_state_q <= rpf_pkg::RX_SYNC;
            end else begin
              rx_zero_q  <= rx_zero_q + 3'h1;
            end
          end
          rpf_pkg::RX_SYNC: begin
            if (rx_octet == rpf_pkg::SFD_BYTE) begin
              rx_state_q <= rpf_pkg::RX_LEN;
              rx_frame_q <= 1'b0;
            end else if (rx_octet != rpf_pkg::PRE_BYTE) begin
              rx_state_q <= rpf_pkg::RX_HUNT;
              rx_zero_q  <= 3'h0;
            end
          end
          rpf_pkg::RX_LEN: begin
            rx_zero_q  <= 3'h0;
            if (rx_accept) begin
              rx_len_q   <= rx_octet[6:0];
              rx_cnt_q   <= 7'h00;
              rx_start_q <= 1'b1;
              rx_frame_q <= 1'b1;
              rx_state_q <= rpf_pkg::RX_BODY;
              if (rx_octet[6:0] == rpf_pkg::LEN_ACK) begin
                rx_kind_q <= rpf_pkg::KIND_ACK;
              end else if (rx_octet[6:0] >= rpf_pkg::LEN_MAC_MIN) begin
                rx_kind_q <= rpf_pkg::KIND_MAC;
              end else begin
                rx_kind_q <= rpf_pkg::KIND_RSVD;
              end
            end else begin
              rx_state_q <= rpf_pkg::RX_HUNT;
            end
          end
          rpf_pkg::RX_BODY: begin
            rx_prev_q <= rx_octet;
            rx_cnt_q  <= rx_cnt_q + 7'h01;
            if (rx_cnt_q == rpf_pkg::FCF_LO_IDX) begin
              rx_fcf_q[7:0]  <= rx_octet;
            end
            if (rx_cnt_q == rpf_pkg::FCF_HI_IDX) begin
              rx_fcf_q[15:8] <= rx_octet;
            end
            if (rx_cnt_q + 7'h01 == rx_len_q) begin
              rx_fcs_q   <= {rx_octet, rx_prev_q};
              rx_done_q  <= 1'b1;
              rx_state_q <= rpf_pkg::RX_HUNT;
            end
          end
          default: rx_state_q <= rpf_pkg::RX_HUNT;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rx_accept) begin
      rx_buf[0] <= rx_octet;
    end else if (rx_store) begin
      rx_buf[7'(rx_cnt_q + 7'h01)] <= rx_octet;
    end
  end

  // ----------------------------------------------------------------
  // host read of the receive buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_ptr_q      <= 7'h00;
      rx_rd_data_q  <= 8'h00;
      rx_rd_valid_q <= 1'b0;
    end else begin
      rx_rd_valid_q <= 1'b0;
      if (rx_start_q) begin
        rx_ptr_q      <= 7'h00;
      end else if (rx_rd_req && rx_frame_q) begin
        rx_rd_data_q  <= rx_buf[rx_ptr_q];
        rx_rd_valid_q <= 1'b1;
        rx_ptr_q      <= rx_ptr_q + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [11:0] shr_cyc_q;
  logic [11:0] gap_q;
  logic        rx_first_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shr_cyc_q  <= 12'h000;
      gap_q      <= 12'h000;
      rx_first_q <= 1'b0;
    end else begin
      rx_first_q <= rx_start_q ? 1'b1 : (rx_rd_req && rx_frame_q) ? 1'b0 : rx_first_q;
      shr_cyc_q <= (tx_state_q == rpf_pkg::TX_SHR) ? shr_cyc_q + 12'h001 :
                   (tx_state_q == rpf_pkg::TX_IDLE) ? 12'h000 : shr_cyc_q;
      gap_q     <= tx_octet_valid_q ? 12'h001 : gap_q + 12'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence tx_go_s;
    tx_state_q == rpf_pkg::TX_IDLE && tx_start;
  endsequence

  sequence rx_open_s;
    rx_first_q && rx_rd_req && rx_frame_q && !rx_start_q;
  endsequence

  shr_preamble_a: assert property (tx_go_s |=> tx_octet_valid_q && tx_octet_q == 8'h00)
    else $error("first header octet not zero");
  shr_delim_a: assert property (tx_octet_valid_q && tx_state_q == rpf_pkg::TX_SHR &&
                                tx_idx_q == 3'h5 |-> tx_octet_q == 8'ha7)
    else $error("delimiter octet wrong");
  shr_time_a: assert property (tx_state_q == rpf_pkg::TX_PHR && $past(tx_state_q) ==
                               rpf_pkg::TX_SHR |-> shr_cyc_q == 12'(rpf_pkg::SHR_CYC))
    else $error("header duration not 3200 cycles");
  len_capture_a: assert property (rx_accept |=> rx_start_q && rx_len_q == $past(rx_octet[6:0]))
    else $error("length not captured from low seven bits");
  zero_drop_a: assert property (rx_state_q == rpf_pkg::RX_LEN && rx_active && rx_octet_valid &&
                                rx_octet[6:0] == 7'h00 |=> !rx_start_q && !rx_frame_q)
    else $error("zero length frame not dropped");
  start_irq_a: assert property (rx_start_q |-> rx_len_q != 7'h00 && rx_frame_q)
    else $error("receive start with zero length");
  first_read_a: assert property (rx_open_s |=> rx_rd_valid_q &&
                                 rx_rd_data_q[6:0] == $past(rx_len_q))
    else $error("first read is not the length octet");
  kind_map_a: assert property (rx_start_q |-> rx_kind_q == (rx_len_q == 7'd5 ? 2'h1 :
                               rx_len_q >= 7'd9 ? 2'h2 : 2'h0))
    else $error("frame kind wrong");
  psdu_gap_a: assert property (tx_octet_valid_q && tx_state_q == rpf_pkg::TX_PSDU &&
                               $past(tx_state_q) == rpf_pkg::TX_PSDU |->
                               gap_q == 12'(rate_period))
    else $error("payload octet spacing wrong");
  underrun_a: assert property (tx_underrun_q |-> tx_state_q == rpf_pkg::TX_IDLE &&
                               !tx_octet_valid_q)
    else $error("underrun did not abort");

endmodule : rpf_framer
`default_nettype wire

// ===== logic/rpf_pkg.sv
// constants, encodings and timing of the packet framer
// assumes a 20 MHz system clock
package rpf_pkg;

  // ----------------------------------------------------------------
  // clock and air timing
  // ----------------------------------------------------------------
  localparam int CLK_NS            = 50;
  localparam int HDR_OCTET_NS      = 32000;
  localparam int HDR_OCTET_CYC     = HDR_OCTET_NS / CLK_NS;
  localparam int SHR_NS            = 160000;
  localparam int SHR_SYMBOLS       = 10;
  localparam int SHR_CYC           = SHR_NS / CLK_NS;
  localparam int PSDU_OCTET_NS_250 = 32000;
  localparam int PSDU_OCTET_NS_500 = 16000;
  localparam int PSDU_OCTET_NS_1K  = 8000;
  localparam int PSDU_OCTET_NS_2K  = 4000;
  localparam int MAX_PSDU_US_250   = 4064;
  localparam int MAX_PSDU_US_2K    = 508;

  localparam int TIM_W = 10;
  localparam logic [TIM_W-1:0] HDR_PERIOD = TIM_W'(HDR_OCTET_CYC);
  localparam logic [TIM_W-1:0] P250       = TIM_W'(PSDU_OCTET_NS_250 / CLK_NS);
  localparam logic [TIM_W-1:0] P500       = TIM_W'(PSDU_OCTET_NS_500 / CLK_NS);
  localparam logic [TIM_W-1:0] P1K        = TIM_W'(PSDU_OCTET_NS_1K / CLK_NS);
  localparam logic [TIM_W-1:0] P2K        = TIM_W'(PSDU_OCTET_NS_2K / CLK_NS);

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam logic [2:0] PRE_OCTETS  = 3'h4;
  localparam logic [2:0] SHR_OCTETS  = 3'h5;
  localparam logic [7:0] PRE_BYTE    = 8'h00;
  localparam logic [7:0] SFD_BYTE    = 8'ha7;
  localparam int         LEN_MSB     = 7;
  localparam logic [6:0] MAX_LEN     = 7'h7f;
  localparam logic [6:0] LEN_ACK     = 7'h05;
  localparam logic [6:0] LEN_MAC_MIN = 7'h09;
  localparam logic [6:0] FCF_LO_IDX  = 7'h00;
  localparam logic [6:0] FCF_HI_IDX  = 7'h01;
  localparam int         BUF_DEPTH   = 128;
  localparam logic [7:0] BUF_FULL    = 8'h80;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_SHR  = 2'h1,
    TX_PHR  = 2'h3,
    TX_PSDU = 2'h2
  } rpf_tx_state_e;

  typedef enum logic [1:0] {
    RX_HUNT = 2'h0,
    RX_SYNC = 2'h1,
    RX_LEN  = 2'h3,
    RX_BODY = 2'h2
  } rpf_rx_state_e;

  typedef enum logic [1:0] {
    KIND_RSVD = 2'h0,
    KIND_ACK  = 2'h1,
    KIND_MAC  = 2'h2
  } rpf_kind_e;

  typedef enum logic [1:0] {
    RATE_250 = 2'h0,
    RATE_500 = 2'h1,
    RATE_1K  = 2'h2,
    RATE_2K  = 2'h3
  } rpf_rate_e;

endpackage : rpf_pkg

// ===== logic/rpf_octet_timer.sv
// octet slot timer: pulses tick at the end of each slot of period cycles
// assumes start only while stopped; period is sampled at each reload
`timescale 1ns/10ps
`default_nettype none
module rpf_octet_timer (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     start,
  input  wire logic                     stop,
  input  wire logic [rpf_pkg::TIM_W-1:0] period,
  output logic                          tick
);

  logic [rpf_pkg::TIM_W-1:0] count_q;
  logic                      run_q;

  assign tick = run_q && (count_q == '0);

  // ----------------------------------------------------------------
  // slot counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
      run_q   <= 1'b0;
    end else if (start) begin
      count_q <= period - 1'b1;
      run_q   <= 1'b1;
    end else if (stop) begin
      run_q   <= 1'b0;
    end else if (run_q) begin
      if (count_q == '0) begin
        count_q <= period - 1'b1;
      end else begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule : rpf_octet_timer
`default_nettype wire

// ===== testbench/rpf_air_model.sv
// far-side radio model: hands received octets to the deframer
// assumes the bench calls one task at a time; drives on rising edges
`timescale 1ns/10ps
`default_nettype none
module rpf_air_model (
  input  wire logic  clk,
  output logic       rx_active,
  output logic       rx_octet_valid,
  output logic [7:0] rx_octet
);
  initial begin
    rx_active = 1'b0;
    rx_octet_valid = 1'b0;
    rx_octet = 8'h00;
  end
  // one octet; afterwards the line shows the inverse of it
  task automatic put(input logic [7:0] v);
    @(posedge clk);
    rx_octet_valid <= 1'b1;
    rx_octet <= v;
    @(posedge clk);
    rx_octet_valid <= 1'b0;
    rx_octet <= ~v;
  endtask : put
  // zero preamble octets, delimiter, length octet
  task automatic head(input int npre, input logic [7:0] lo);
    @(posedge clk);
    rx_active <= 1'b1;
    for (int i = 0; i < npre; i++) put(8'h00);
    put(8'ha7);
    put(lo);
  endtask : head
  task automatic stop();
    @(posedge clk);
    rx_active <= 1'b0;
  endtask : stop
endmodule : rpf_air_model
`default_nettype wire

// ===== testbench/test_radio_ppdu_framer.sv
// bench for the packet framer: transmit framing and receive deframing
// assumes a 20 MHz clock and the far-side model rpf_air_model
`timescale 1ns/10ps
`default_nettype none
module test_radio_ppdu_framer;
  logic        clk, rst_b, tx_start, tx_wr_valid, rx_rd_req;
  logic [1:0]  tx_rate, rx_kind;
  logic [7:0]  tx_wr_data, tx_octet, rx_octet, rx_rd_data;
  logic        tx_busy, tx_octet_valid, tx_done, tx_underrun;
  logic        rx_active, rx_octet_valid, rx_start_irq, rx_done;
  logic        rx_frame_avail, rx_rd_valid;
  logic [15:0] rx_fcf, rx_fcs;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          kbps [4] = '{250, 500, 1000, 2000};

  rpf_framer dut_u (.clk(clk), .rst_b(rst_b), .tx_start(tx_start), .tx_rate(tx_rate),
    .tx_wr_valid(tx_wr_valid), .tx_wr_data(tx_wr_data), .tx_busy(tx_busy),
    .tx_octet(tx_octet), .tx_octet_valid(tx_octet_valid), .tx_done(tx_done),
    .tx_underrun(tx_underrun), .rx_active(rx_active), .rx_octet_valid(rx_octet_valid),
    .rx_octet(rx_octet), .rx_start_irq(rx_start_irq), .rx_done(rx_done),
    .rx_frame_avail(rx_frame_avail), .rx_kind(rx_kind), .rx_fcf(rx_fcf),
    .rx_fcs(rx_fcs), .rx_rd_req(rx_rd_req), .rx_rd_data(rx_rd_data),
    .rx_rd_valid(rx_rd_valid));
  rpf_air_model air_u (.clk(clk), .rx_active(rx_active),
    .rx_octet_valid(rx_octet_valid), .rx_octet(rx_octet));

  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [7:0] pb(input int k);
    return 8'(k + 64);
  endfunction : pb
  task automatic rd(input logic [7:0] e);
    @(posedge clk);
    rx_rd_req <= 1'b1;
    @(posedge clk);
    rx_rd_req <= 1'b0;
    #1;
    chk("rd valid", 1, rx_rd_valid);
    chk("rd data", e, rx_rd_data);
  endtask : rd

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // start first, then load length and payload while the header is on air
  task automatic tx_run(input logic [1:0] r, input logic [7:0] lo, input int nwr);
    int p, t, i, len;
    logic [7:0] e;
    p = 160000 / kbps[r];
    len = int'(lo[6:0]);
    i = 0;
    @(posedge clk);
    tx_start <= 1'b1;
    tx_rate <= r;
    for (t = 1; t < 20000; t++) begin
      @(posedge clk);
      tx_start <= (t == 100);
      tx_wr_valid <= (t <= nwr);
      tx_wr_data <= (t == 1) ? lo : pb(t - 1);
      #1;
      if (tx_octet_valid === 1'b1) begin
        e = (i < 4) ? 8'h00 : (i == 4) ? 8'ha7 : (i == 5) ? lo : pb(i - 5);
        chk("tx octet", e, tx_octet);
        if (i == 0) chk("tx busy run", 1, tx_busy);
        chk("tx slot", (i < 6) ? 640 * i + 1 : 3841 + (i - 6) * p, t);
        i++;
      end
      if (tx_done === 1'b1 || tx_underrun === 1'b1) break;
    end
    if (nwr > len) begin
      chk("tx done", 3841 + len * p, t);
      chk("tx octets", len + 6, i);
    end else begin
      chk("tx underrun", 3841 + (nwr - 1) * p, t);
      chk("underrun octets", nwr + 5, i);
    end
    chk("tx done flag", nwr > len, tx_done);
    chk("tx busy", 0, tx_busy);
  endtask : tx_run

  task automatic rx_run(input logic [7:0] lo, input logic [1:0] kd);
    int len;
    len = int'(lo[6:0]);
    air_u.head(4, lo);
    #1;
    chk("rx irq", 1, rx_start_irq);
    chk("rx kind", kd, rx_kind);
    chk("rx avail", 1, rx_frame_avail);
    for (int k = 1; k <= len; k++) begin
      air_u.put(pb(k));
      #1;
      chk("rx done", k == len, rx_done);
    end
    chk("rx fcf", {pb(2), pb(1)}, rx_fcf);
    chk("rx fcs", {pb(len), pb(len - 1)}, rx_fcs);
    air_u.stop();
    rd(lo);
    for (int k = 1; k <= len; k++) rd(pb(k));
  endtask : rx_run

  // zero length with top bit set, then a short preamble
  task automatic rx_bad();
    air_u.head(4, 8'h80);
    #1;
    chk("zero irq", 0, rx_start_irq);
    chk("zero avail", 0, rx_frame_avail);
    air_u.stop();
    air_u.head(3, 8'h05);
    #1;
    chk("short irq", 0, rx_start_irq);
    air_u.stop();
    @(posedge clk);
    rx_rd_req <= 1'b1;
    @(posedge clk);
    rx_rd_req <= 1'b0;
    #1;
    chk("dropped read", 0, rx_rd_valid);
  endtask : rx_bad

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  initial begin
    #3000000;
    bad_count++;
    conclude();
  end

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    tx_start = 1'b0;
    tx_rate = 2'h0;
    tx_wr_valid = 1'b0;
    tx_wr_data = 8'h00;
    rx_rd_req = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk("reset busy", 0, tx_busy);
    @(posedge clk);
    rst_b <= 1'b1;
    for (int r = 0; r < 4; r++) tx_run(2'(r), (r == 3) ? 8'hff : 8'h83, (r == 3) ? 128 : 4);
    tx_run(2'h3, 8'h05, 3);
    tx_run(2'h2, 8'h02, 3);
    rx_run(8'h85, 2'h1);
    rx_run(8'h09, 2'h2);
    rx_run(8'h06, 2'h0);
    rx_run(8'h7f, 2'h2);
    rx_bad();
    conclude();
  end
endmodule : test_radio_ppdu_framer
`default_nettype wire
